// ### dv/ttcfg_regs_bench.sv
module ttcfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ttcfg_pkg::*;

  logic                                 aclk;
  logic                                 aresetn;
  logic [AXI_ADDR_W-1:0]                awaddr;
  logic [AXI_ADDR_W-1:0]                araddr;
  logic [2:0]                           awprot;
  logic [2:0]                           arprot;
  logic                                 awvalid;
  logic                                 awready;
  logic                                 wvalid;
  logic                                 wready;
  logic [AXI_DATA_W-1:0]                wdata;
  logic [AXI_DATA_W-1:0]                rdata;
  logic [3:0]                           wstrb;
  logic [1:0]                           bresp;
  logic [1:0]                           rresp;
  logic                                 bvalid;
  logic                                 bready;
  logic                                 arvalid;
  logic                                 arready;
  logic                                 rvalid;
  logic                                 rready;
  logic signed [3:0]                    lvl_off;
  logic [N_POINTS-1:0][TIME_W-1:0]      dly_us;
  logic [N_POINTS-1:0][ABS_W-1:0]       abs_us;
  logic                                 times_valid;
  int                                   num_errors = 0;
  int                                   tests_run = 0;
  int                                   lut_us [16] = '{100, 200, 300, 400,
    600, 800, 1000, 1200, 1400, 2000, 2400, 3200, 4000, 5200, 6400, 8000};

  ttcfg_regs u_ttcfg_regs (
    .aclk                         (aclk),
    .aresetn                      (aresetn),
    .awaddr                       (awaddr),
    .awprot                       (awprot),
    .awvalid                      (awvalid),
    .awready                      (awready),
    .wdata                        (wdata),
    .wstrb                        (wstrb),
    .wvalid                       (wvalid),
    .wready                       (wready),
    .bresp                        (bresp),
    .bvalid                       (bvalid),
    .bready                       (bready),
    .araddr                       (araddr),
    .arprot                       (arprot),
    .arvalid                      (arvalid),
    .arready                      (arready),
    .rdata                        (rdata),
    .rresp                        (rresp),
    .rvalid                       (rvalid),
    .rready                       (rready),
    .first_preset_level_offset    (lvl_off),
    .second_preset_point_delta_us (dly_us),
    .second_preset_point_time_us  (abs_us),
    .second_preset_times_valid    (times_valid)
  );

  always #2.5 aclk = ~aclk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic hang(input int n);
    if (n > 100) begin
      $display("ERROR t=%0t no answer got %h exp %h", $time, 0, 1);
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic axi_write(input logic [AXI_ADDR_W-1:0] a,
                           input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int   n;
    logic aw_done;
    logic w_done;
    logic got;
    n = 0;
    aw_done = 0;
    w_done = 0;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        got = 1;
        r = bresp;
        bready <= 1'b0;
      end
      hang(n);
    end
  endtask

  task automatic axi_read(input logic [AXI_ADDR_W-1:0] a,
                          output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic got;
    n = 0;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        got = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
      hang(n);
    end
  endtask

  task automatic wr(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, {24'h0, d}, 4'h1, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    $display("ERROR t=%0t watchdog got %h exp %h", $time, 0, 1);
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [3:0]  c [6];
    logic [3:0]  o;
    logic [3:0]  e;
    logic [1:0]  r;
    int          sum;
    aclk = 0;
    aresetn = 0;
    awaddr = '0;
    araddr = '0;
    awprot = '0;
    arprot = '0;
    awvalid = 0;
    wvalid = 0;
    wdata = '0;
    wstrb = '0;
    bready = 0;
    arvalid = 0;
    rready = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({31'h0, times_valid}, 32'h0);
    // points stay unusable until all three time registers are written
    wr(ADDR_PTS_A, 8'h12, RESP_OKAY);
    wr(ADDR_PTS_B, 8'h34, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, times_valid}, 32'h0);
    $display("test power-up done");
    // each point sweeps all sixteen codes over the loop
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < 6; i++) c[i] = 4'((k + i) % 16);
      wr(ADDR_PTS_A, {c[0], c[1]}, RESP_OKAY);
      wr(ADDR_PTS_B, {c[2], c[3]}, RESP_OKAY);
      wr(ADDR_PTS_C, {c[4], c[5]}, RESP_OKAY);
      repeat (3) @(posedge aclk);
      sum = 0;
      for (int i = 0; i < 6; i++) begin
        sum += lut_us[c[i]];
        chk(32'(dly_us[i]), 32'(lut_us[c[i]]));
        chk(32'(abs_us[i]), 32'(sum));
      end
      chk({31'h0, times_valid}, 32'h1);
      rd(ADDR_PTS_A, {24'h0, c[0], c[1]}, RESP_OKAY);
      rd(ADDR_PTS_B, {24'h0, c[2], c[3]}, RESP_OKAY);
      rd(ADDR_PTS_C, {24'h0, c[4], c[5]}, RESP_OKAY);
    end
    $display("test time points done");
    // upper nibble written nonzero, must read back as zero
    for (int k = 0; k < 16; k++) begin
      o = 4'(k);
      e = o[3] ? ((o[2:0] == 3'h0) ? 4'h8 : 4'h0 - {1'b0, o[2:0]}) : o;
      wr(ADDR_OFFSET, {4'ha, o}, RESP_OKAY);
      rd(ADDR_OFFSET, {28'h0, o}, RESP_OKAY);
      chk({28'h0, lvl_off}, {28'h0, e});
    end
    $display("test offset done");
    wr(12'h1c8, 8'h3c, RESP_SLVERR);
    rd(12'h1c8, 32'h0, RESP_SLVERR);
    axi_write(ADDR_PTS_C, 32'h000000ff, 4'h0, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_PTS_C, {24'h0, c[4], c[5]}, RESP_OKAY);
    $display("test refused access done");
    report_and_stop();
  end
endmodule

// ### rtl/ttcfg_pkg.sv
package ttcfg_pkg;

  // bus geometry
  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_OFFSET = 8'h6e;
  localparam logic [7:0]  IDX_PTS_A  = 8'h6f;
  localparam logic [7:0]  IDX_PTS_B  = 8'h70;
  localparam logic [7:0]  IDX_PTS_C  = 8'h71;

  localparam logic [AXI_ADDR_W-1:0] ADDR_OFFSET = {2'h0, IDX_OFFSET, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_PTS_A  = {2'h0, IDX_PTS_A, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_PTS_B  = {2'h0, IDX_PTS_B, 2'h0};
  localparam logic [AXI_ADDR_W-1:0] ADDR_PTS_C  = {2'h0, IDX_PTS_C, 2'h0};

  // field layout
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned HI_NIB_LSB = 4;
  localparam int unsigned LO_NIB_LSB = 0;
  localparam int unsigned N_POINTS   = 6;

  // widths of decoded times in microseconds
  localparam int unsigned TIME_W = 14;
  localparam int unsigned ABS_W  = 16;

  // code to duration table, microseconds
  localparam logic [TIME_W-1:0] TIME_US_LUT [16] = '{
    14'h0064, 14'h00c8, 14'h012c, 14'h0190,
    14'h0258, 14'h0320, 14'h03e8, 14'h04b0,
    14'h0578, 14'h07d0, 14'h0960, 14'h0c80,
    14'h0fa0, 14'h1450, 14'h1900, 14'h1f40
  };

  // bus answers and reset values of control state
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] WRITTEN_RST = 3'h0;

  typedef enum logic [0:0] {
    TTCFG_RD_IDLE = 1'b0,
    TTCFG_RD_RESP = 1'b1
  } ttcfg_rd_e;

endpackage

// ### rtl/ttcfg_regs.sv
// Summary of operation
// - offset nibble bits 3:0, sign-magnitude, 7..-8
// - point1 absolute time in bits 7:4
// - point2 delta in bits 3:0
// - point3 delta in next register 7:4
// - point4 delta in that register 3:0
// - point5 delta in third register 7:4
// - codes 0..7 give 100 to 1200 us
// - codes 8..15 give 1400 to 8000 us
// - fields undefined until software writes them
// - time registers at indices 6f, 70, 71
// - point6 delta in third register 3:0
//
// The AXI4-Lite slave port is this design's own decision.
module ttcfg_regs (
  // clock and reset
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  // write address
  input  wire logic [ttcfg_pkg::AXI_ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                          awprot,
  input  wire logic                                awvalid,
  output logic                                     awready,
  // write data
  input  wire logic [ttcfg_pkg::AXI_DATA_W-1:0]    wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  // write response
  output logic      [1:0]                          bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  // read address
  input  wire logic [ttcfg_pkg::AXI_ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                          arprot,
  input  wire logic                                arvalid,
  output logic                                     arready,
  // read data
  output logic      [ttcfg_pkg::AXI_DATA_W-1:0]    rdata,
  output logic      [1:0]                          rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // threshold configuration to comparator
  output logic signed [3:0]                        first_preset_level_offset,
  output logic      [ttcfg_pkg::N_POINTS-1:0][ttcfg_pkg::TIME_W-1:0]
                                                   second_preset_point_delta_us,
  output logic      [ttcfg_pkg::N_POINTS-1:0][ttcfg_pkg::ABS_W-1:0]
                                                   second_preset_point_time_us,
  output logic                                     second_preset_times_valid
);
  import ttcfg_pkg::*;

  // configuration storage, deliberately without reset; only written_q is reset
  logic [NIB_W-1:0]      preset1_level_offset_q;
  logic [7:0]            preset2_time_points_a_q;
  logic [7:0]            preset2_time_points_b_q;
  logic [7:0]            preset2_time_points_c_q;
  logic [2:0]            written_q;

  // write channel state
  logic                  aw_held_q;
  logic                  w_held_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [AXI_DATA_W-1:0] wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  wr_fire;
  logic                  wr_hit;
  logic                  wr_lane0;

  // read channel state
  ttcfg_rd_e             rd_state_q;
  logic [AXI_DATA_W-1:0] rdata_q;
  logic [1:0]            rresp_q;
  logic [AXI_DATA_W-1:0] rdata_d;
  logic                  rd_hit;
  logic                  ar_hs;

  // decoded fields
  logic [N_POINTS-1:0][NIB_W-1:0]  point_code;
  logic [N_POINTS-1:0][TIME_W-1:0] point_span;
  logic [N_POINTS-1:0][ABS_W-1:0]  point_abs_d;
  logic signed [3:0]               offset_d;

  // write address and data are taken independently
  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready  = ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (awvalid && awready) begin
      awaddr_q <= awaddr;
    end
    if (wvalid && wready) begin
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
  end

  // address decode of the held write
  always_comb begin
    wr_hit = (awaddr_q == ADDR_OFFSET) || (awaddr_q == ADDR_PTS_A) ||
             (awaddr_q == ADDR_PTS_B) || (awaddr_q == ADDR_PTS_C);
  end

  assign wr_lane0 = wr_fire & wr_hit & wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // offset register: only the low nibble is stored
  always_ff @(posedge aclk) begin
    if (wr_lane0 && awaddr_q == ADDR_OFFSET) begin
      preset1_level_offset_q <= wdata_q[NIB_W-1:0];
    end
  end

  // time point registers, no reset value
  always_ff @(posedge aclk) begin
    if (wr_lane0 && awaddr_q == ADDR_PTS_A) begin
      preset2_time_points_a_q <= wdata_q[7:0];
    end
    if (wr_lane0 && awaddr_q == ADDR_PTS_B) begin
      preset2_time_points_b_q <= wdata_q[7:0];
    end
    if (wr_lane0 && awaddr_q == ADDR_PTS_C) begin
      preset2_time_points_c_q <= wdata_q[7:0];
    end
  end

  // tracks which time registers hold software values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      written_q <= WRITTEN_RST;
    end else if (wr_lane0) begin
      if (awaddr_q == ADDR_PTS_A) begin
        written_q[0] <= 1'b1;
      end
      if (awaddr_q == ADDR_PTS_B) begin
        written_q[1] <= 1'b1;
      end
      if (awaddr_q == ADDR_PTS_C) begin
        written_q[2] <= 1'b1;
      end
    end
  end

  assign second_preset_times_valid = &written_q;

  // read channel
  assign ar_hs   = arvalid & arready;
  assign arready = (rd_state_q == TTCFG_RD_IDLE);

  always_comb begin
    rd_hit  = 1'b1;
    rdata_d = '0;
    case (araddr)
      ADDR_OFFSET: begin
        rdata_d[NIB_W-1:0] = preset1_level_offset_q;
      end
      ADDR_PTS_A: begin
        rdata_d[7:0] = preset2_time_points_a_q;
      end
      ADDR_PTS_B: begin
        rdata_d[7:0] = preset2_time_points_b_q;
      end
      ADDR_PTS_C: begin
        rdata_d[7:0] = preset2_time_points_c_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= TTCFG_RD_IDLE;
    end else begin
      case (rd_state_q)
        TTCFG_RD_IDLE: begin
          if (arvalid) begin
            rd_state_q <= TTCFG_RD_RESP;
          end
        end
        TTCFG_RD_RESP: begin
          if (rready) begin
            rd_state_q <= TTCFG_RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= TTCFG_RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rdata_q <= rdata_d;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  assign rvalid = (rd_state_q == TTCFG_RD_RESP);
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  // field extraction
  always_comb begin
    point_code[0] = preset2_time_points_a_q[HI_NIB_LSB +: NIB_W];
    point_code[1] = preset2_time_points_a_q[LO_NIB_LSB +: NIB_W];
    point_code[2] = preset2_time_points_b_q[HI_NIB_LSB +: NIB_W];
    point_code[3] = preset2_time_points_b_q[LO_NIB_LSB +: NIB_W];
    point_code[4] = preset2_time_points_c_q[HI_NIB_LSB +: NIB_W];
    point_code[5] = preset2_time_points_c_q[LO_NIB_LSB +: NIB_W];
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_POINTS; gi++) begin : g_dec
      ttcfg_time_decode #(
        .CODE_W (NIB_W),
        .OUT_W  (TIME_W)
      ) u_dec (
        .code    (point_code[gi]),
        .time_us (point_span[gi])
      );
    end
  endgenerate

  // running sum from the absolute first point
  always_comb begin
    point_abs_d[0] = ABS_W'(point_span[0]);
    for (int i = 1; i < N_POINTS; i++) begin
      point_abs_d[i] = point_abs_d[i-1] + ABS_W'(point_span[i]);
    end
  end

  // sign-magnitude; negative zero taken as the -8 end
  always_comb begin
    if (!preset1_level_offset_q[3]) begin
      offset_d = $signed({1'b0, preset1_level_offset_q[2:0]});
    end else if (preset1_level_offset_q[2:0] == 3'h0) begin
      offset_d = -4'sd8;
    end else begin
      offset_d = -$signed({1'b0, preset1_level_offset_q[2:0]});
    end
  end

  always_ff @(posedge aclk) begin
    first_preset_level_offset    <= offset_d;
    second_preset_point_delta_us <= point_span;
    second_preset_point_time_us  <= point_abs_d;
  end

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_offset_signed:
    assert property ((wr_lane0 && awaddr_q == ADDR_OFFSET &&
                      wdata_q[3:0] == 4'hb) |=> ##1
                     first_preset_level_offset == -4'sd3)
    else $error("offset sign-magnitude decode wrong");
  a_point1_absolute:
    assert property ((wr_lane0 && awaddr_q == ADDR_PTS_A &&
                      wdata_q[7:4] == 4'h0) |=> ##1
                     second_preset_point_time_us[0] == 16'h0064)
    else $error("point1 absolute time wrong");
  a_point2_delta:
    assert property ((preset2_time_points_a_q == 8'h12) |=>
                     second_preset_point_time_us[1] == 16'h01f4)
    else $error("point2 not added to point1");
  a_point3_field:
    assert property ((preset2_time_points_b_q[7:4] == 4'hf) |=>
                     second_preset_point_delta_us[2] == 14'h1f40)
    else $error("point3 field or decode wrong");
  a_point4_field:
    assert property ((preset2_time_points_b_q[3:0] == 4'h8) |=>
                     second_preset_point_delta_us[3] == 14'h0578)
    else $error("point4 field or decode wrong");
  a_point5_field:
    assert property ((preset2_time_points_c_q[7:4] == 4'h4) |=>
                     second_preset_point_delta_us[4] == 14'h0258)
    else $error("point5 field or decode wrong");
  a_code_low:
    assert property ((preset2_time_points_a_q[7:4] == 4'h7) |=>
                     second_preset_point_delta_us[0] == 14'h04b0)
    else $error("low code table entry wrong");
  a_code_high:
    assert property ((preset2_time_points_a_q[3:0] == 4'hd) |=>
                     second_preset_point_delta_us[1] == 14'h1450)
    else $error("high code table entry wrong");
  a_valid_needs_write:
    assert property ($rose(second_preset_times_valid) |->
                     $past(wr_lane0))
    else $error("times valid without a write");
  a_readback_b:
    assert property ((ar_hs && araddr == ADDR_PTS_B) |=>
                     rvalid && rresp == RESP_OKAY &&
                     rdata == {24'h0, $past(preset2_time_points_b_q)})
    else $error("register b read back wrong");
  a_point6_field:
    assert property ((preset2_time_points_c_q[3:0] == 4'h9) |=>
                     second_preset_point_delta_us[5] == 14'h07d0)
    else $error("point6 field or decode wrong");
  // point6 time output is unknown until a cycle after all three registers hold values
  a_cumulative_sum:
    assert property ($past(second_preset_times_valid) |->
                     second_preset_point_time_us[5] ==
                     second_preset_point_time_us[4] +
                     ABS_W'(second_preset_point_delta_us[5]))
    else $error("point6 time is not previous plus delta");
  a_offset_upper_zero:
    assert property ((ar_hs && araddr == ADDR_OFFSET) |=>
                     rdata[31:4] == 28'h0)
    else $error("offset upper bits not zero on read");
  a_unmapped_error:
    assert property ((wr_fire && !wr_hit) |=>
                     bvalid && bresp == RESP_SLVERR)
    else $error("unmapped write not answered with error");
  c_write_time_reg:
    cover property (wr_lane0 && awaddr_q == ADDR_PTS_C);
  c_all_written:
    cover property ($rose(second_preset_times_valid));
  c_read_offset:
    cover property (ar_hs && araddr == ADDR_OFFSET);
  c_unmapped_read:
    cover property (ar_hs && !rd_hit);

endmodule

// ### rtl/ttcfg_time_decode.sv
module ttcfg_time_decode #(
  parameter int unsigned CODE_W = 4,
  parameter int unsigned OUT_W  = 14
) (
  // code in
  input  wire logic [CODE_W-1:0] code,
  // duration out
  output logic      [OUT_W-1:0]  time_us
);
  import ttcfg_pkg::*;

  // sixteen-entry duration table
  always_comb begin
    time_us = OUT_W'(TIME_US_LUT[code]);
  end

endmodule
